// [verilog/wtg_pkg.sv]
`default_nettype none
package wtg_pkg;
	// counter and register widths
	localparam int         CNT_W         = 24;
	localparam int         OFS_W         = 8;
	localparam int         ST_W          = 3;
	// register byte offsets
	localparam logic [7:0] OFS_MODE      = 8'h00;
	localparam logic [7:0] OFS_RELOAD    = 8'h04;
	localparam logic [7:0] OFS_FEED      = 8'h08;
	localparam logic [7:0] OFS_COUNT     = 8'h0C;
	localparam logic [7:0] OFS_WARN      = 8'h10;
	localparam logic [7:0] OFS_WINDOW    = 8'h14;
	localparam logic [7:0] OFS_STATUS    = 8'h18;
	localparam logic [7:0] OFS_MASK      = 8'h1C;
	localparam logic [7:0] OFS_CAUSE     = 8'h20;
	// reset values and limits
	localparam logic [23:0] RELOAD_MIN   = 24'h0000FF;
	localparam logic [23:0] RELOAD_RST   = 24'h0000FF;
	localparam logic [23:0] WARN_RST     = 24'h000000;
	localparam logic [23:0] WINDOW_RST   = 24'hFFFFFF;
	localparam logic [2:0]  ST_RST       = 3'h0;
	// feed key pair, written back to back
	localparam logic [7:0] FEED_FIRST    = 8'hAA;
	localparam logic [7:0] FEED_SECOND   = 8'h55;
	// fixed divide-by-four prescaler
	localparam logic [1:0] PSC_LAST      = 2'h3;
	localparam logic [1:0] PSC_RST       = 2'h0;
	// mclk cycles per guard tick (100 MHz -> 1 MHz)
	localparam int         TICK_DIV_DFLT = 100;
	// bus constants
	localparam int         TRANS_ACT_BIT = 1;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;
	localparam logic       HRESP_OKAY    = 1'b0;
	// mode register layout, bit 0 is enable
	typedef struct packed {
		logic sleepRun;   // keep counting in deep sleep
		logic protect;    // guard the reload value
		logic resetEn;    // trip resets the chip
		logic enable;     // sticky run enable
	} wtg_mode_t;
	localparam wtg_mode_t MODE_RST = 4'h0;
	// event and status layout, bit 0 is time-out
	typedef struct packed {
		logic fault;      // bad or early feed
		logic warn;       // warning point reached
		logic timeout;    // counter expired
	} wtg_evt_t;
	// feed sequencer states
	typedef enum logic {FEED_IDLE, FEED_ARMED} wtg_feed_state_t;
endpackage : wtg_pkg
`default_nettype wire

// [verilog/wtg_tick_div.sv]
`timescale 1ns/1ns
`default_nettype none
module wtg_tick_div
	import wtg_pkg::*;
#(
	parameter int DIV = TICK_DIV_DFLT
) (
	input  wire logic mclk,
	input  wire logic resetn,
	output logic      guardTick
);
	// refuse a ratio the counter cannot serve
	if (DIV < 2) begin : g_chk
		$error("wtg_tick_div: DIV must be at least 2");
	end
	localparam int DW = $clog2(DIV);
	localparam logic [DW-1:0] LAST = DW'(DIV - 1);
	logic [DW-1:0] div_ff;    // cycle count inside one tick
	// free running divider
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			div_ff <= '0;
		end else if (div_ff == LAST) begin
			div_ff <= '0;
		end else begin
			div_ff <= div_ff + DW'(1);
		end
	end
	// one-cycle tick pulse from a flop
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			guardTick <= 1'b0;
		end else begin
			guardTick <= (div_ff == LAST);
		end
	end
endmodule : wtg_tick_div
`default_nettype wire

// [verilog/wtg_feed_seq.sv]
`timescale 1ns/1ns
`default_nettype none
module wtg_feed_seq
	import wtg_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       resetn,
	input  wire logic       access,
	input  wire logic       isFeed,
	input  wire logic       isWrite,
	input  wire logic [7:0] wdata,
	output logic            feedOk,
	output logic            feedBad
);
	wtg_feed_state_t state_ff;   // waiting for first or second key
	logic            keyWr;      // write to the feed register
	assign keyWr = access && isFeed && isWrite;
	always_comb begin
		feedOk  = 1'b0;
		feedBad = 1'b0;
		case (state_ff)
			FEED_IDLE: begin
				// a wrong key alone is a bad feed
				feedBad = keyWr && (wdata != FEED_FIRST);
			end
			FEED_ARMED: begin
				// only the second key may follow
				feedOk  = keyWr && (wdata == FEED_SECOND);
				feedBad = access && !feedOk;
			end
			default: begin
				feedBad = 1'b0;
			end
		endcase
	end
	// state advances on each bus access
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= FEED_IDLE;
		end else if (access) begin
			if (state_ff == FEED_IDLE && keyWr && wdata == FEED_FIRST) begin
				state_ff <= FEED_ARMED;
			end else begin
				state_ff <= FEED_IDLE;
			end
		end
	end
endmodule : wtg_feed_seq
`default_nettype wire

// [verilog/windowed_timeout_guard.sv]
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module windowed_timeout_guard
	import wtg_pkg::*;
#(
	parameter int TICK_DIV = TICK_DIV_DFLT
) (
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        sleepMode,
	output logic             chipResetReq,
	output logic             irq
);
	// register state
	wtg_mode_t         mode_ff;      // mode bits
	logic [CNT_W-1:0]  reload_ff;    // reload value
	logic [CNT_W-1:0]  warn_ff;      // warning compare point
	logic [CNT_W-1:0]  window_ff;    // highest count a feed may hit
	logic [CNT_W-1:0]  count_ff;     // down counter
	logic [1:0]        psc_ff;       // prescaler phase
	wtg_evt_t          status_ff;    // sticky events
	wtg_evt_t          mask_ff;      // interrupt mask
	logic              cause_ff;     // last reset came from watchdog
	logic              chipReset_ff; // reset request pulse
	// bus pipeline state
	logic              aValid_ff;    // data phase in progress
	logic              aWrite_ff;    // data phase is a write
	logic [OFS_W-1:0]  aOfs_ff;      // offset of data phase
	logic              rdWait_ff;    // read wait state
	logic [31:0]       hrdata_ff;    // read data
	// combinational terms
	logic              addrTake;     // address phase accepted
	logic              wrStrobe;     // write data on hwdata
	logic              wrMode;
	logic              wrReload;
	logic              wrWarn;
	logic              wrWindow;
	logic              wrStatus;
	logic              wrMask;
	logic              wrCause;
	logic              guardTick;    // one pulse per guard clock
	logic              feedOk;       // key pair completed
	logic              feedBad;      // broken key pair
	logic              running;      // counter advances on ticks
	logic              stepNow;      // counter steps this cycle
	logic [CNT_W-1:0]  nxt_count;    // count after one step
	logic              timeoutHit;   // counter expired
	logic              warnHit;      // warning point reached
	logic              feedEarly;    // feed before the window
	logic              faultHit;     // feed fault while enabled
	logic              trip;         // watchdog event
	logic              wdReset;      // event in reset mode
	logic              enableRise;   // software starts the counter
	wtg_mode_t         modeWr;       // mode bits carried by a write
	logic              feedGood;     // valid feed reloads
	logic              reloadOpen;   // reload may change
	wtg_evt_t          evtSet;       // events into status
	logic [31:0]       nxt_rdata;    // read mux output

	// raise writes below the shortest time-out
	function automatic logic [CNT_W-1:0] clampReload(input logic [CNT_W-1:0] v);
		return (v < RELOAD_MIN) ? RELOAD_MIN : v;
	endfunction : clampReload

	// zero-extend a counter field onto the bus
	function automatic logic [31:0] busWord(input logic [CNT_W-1:0] v);
		return {{(32 - CNT_W){1'b0}}, v};
	endfunction : busWord

	wtg_tick_div #(
		.DIV       (TICK_DIV)
	) u_tick (
		.mclk      (mclk),
		.resetn    (resetn),
		.guardTick (guardTick)
	);

	wtg_feed_seq u_feed (
		.mclk      (mclk),
		.resetn    (resetn),
		.access    (aValid_ff && !rdWait_ff),
		.isFeed    (aOfs_ff == OFS_FEED),
		.isWrite   (aWrite_ff),
		.wdata     (hwdata[7:0]),
		.feedOk    (feedOk),
		.feedBad   (feedBad)
	);

	// bus decode, word transfers only
	assign addrTake  = hsel && hready && htrans[TRANS_ACT_BIT] && (hsize == HSIZE_WORD);
	assign wrStrobe  = aValid_ff && aWrite_ff;
	assign wrMode    = wrStrobe && (aOfs_ff == OFS_MODE);
	assign wrReload  = wrStrobe && (aOfs_ff == OFS_RELOAD);
	assign wrWarn    = wrStrobe && (aOfs_ff == OFS_WARN);
	assign wrWindow  = wrStrobe && (aOfs_ff == OFS_WINDOW);
	assign wrStatus  = wrStrobe && (aOfs_ff == OFS_STATUS);
	assign wrMask    = wrStrobe && (aOfs_ff == OFS_MASK);
	assign wrCause   = wrStrobe && (aOfs_ff == OFS_CAUSE);
	// mode fields laid over the low write data bits
	assign modeWr    = wtg_mode_t'(hwdata[$bits(wtg_mode_t)-1:0]);
	// reads take one wait state, writes none
	assign hreadyout = !rdWait_ff;
	assign hresp     = HRESP_OKAY;
	assign hrdata    = hrdata_ff;

	// pause in deep sleep unless told to run
	assign running    = mode_ff.enable && (!sleepMode || mode_ff.sleepRun);
	// step once every four guard ticks
	assign stepNow    = running && guardTick && (psc_ff == PSC_LAST);
	assign nxt_count  = count_ff - CNT_W'(1);
	// expiry when a step finds zero
	assign timeoutHit = stepNow && (count_ff == '0);
	// warning when the step lands on the point
	assign warnHit    = stepNow && (count_ff != '0) && (nxt_count == warn_ff);
	// feed above the window is early
	assign feedEarly  = feedOk && (count_ff > window_ff);
	// bad feed trips only while enabled
	assign faultHit   = mode_ff.enable && (feedBad || feedEarly);
	assign trip       = timeoutHit || faultHit;
	// reset mode turns the event into chip reset
	assign wdReset    = trip && mode_ff.resetEn;
	assign enableRise = wrMode && modeWr.enable && !mode_ff.enable;
	assign feedGood   = feedOk && !feedEarly;
	// protected reload opens at the warning point
	assign reloadOpen = !mode_ff.protect || (count_ff <= warn_ff);
	assign evtSet     = '{fault: faultHit, warn: warnHit, timeout: timeoutHit};

	// address phase capture
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			aValid_ff <= 1'b0;
			aWrite_ff <= 1'b0;
			aOfs_ff   <= '0;
		end else if (hready) begin
			aValid_ff <= addrTake;
			aWrite_ff <= hwrite;
			aOfs_ff   <= haddr[OFS_W-1:0];
		end else begin
			// hold offset through the wait state
			aValid_ff <= aValid_ff;
		end
	end

	// read wait state flag
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rdWait_ff <= 1'b0;
		end else begin
			rdWait_ff <= addrTake && !hwrite;
		end
	end

	// read mux, unmapped offsets read zero
	always_comb begin
		nxt_rdata = '0;
		case (aOfs_ff)
			OFS_MODE:   nxt_rdata = {28'h0000000, mode_ff};
			OFS_RELOAD: nxt_rdata = busWord(reload_ff);
			OFS_COUNT:  nxt_rdata = busWord(count_ff);
			OFS_WARN:   nxt_rdata = busWord(warn_ff);
			OFS_WINDOW: nxt_rdata = busWord(window_ff);
			OFS_STATUS: nxt_rdata = {29'h00000000, status_ff};
			OFS_MASK:   nxt_rdata = {29'h00000000, mask_ff};
			OFS_CAUSE:  nxt_rdata = {31'h00000000, cause_ff};
			default:    nxt_rdata = '0;
		endcase
	end

	// read data sampled in the wait state
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			hrdata_ff <= '0;
		end else if (rdWait_ff) begin
			hrdata_ff <= nxt_rdata;
		end
	end

	// mode register
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mode_ff <= MODE_RST;
		end else if (wdReset) begin
			// only a watchdog reset clears enable
			mode_ff <= MODE_RST;
		end else if (wrMode) begin
			mode_ff.enable   <= mode_ff.enable | modeWr.enable;
			mode_ff.resetEn  <= modeWr.resetEn;
			mode_ff.protect  <= modeWr.protect;
			mode_ff.sleepRun <= modeWr.sleepRun;
		end
	end

	// configuration registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			reload_ff <= RELOAD_RST;
			warn_ff   <= WARN_RST;
			window_ff <= WINDOW_RST;
		end else if (wdReset) begin
			reload_ff <= RELOAD_RST;
			warn_ff   <= WARN_RST;
			window_ff <= WINDOW_RST;
		end else begin
			if (wrReload && reloadOpen) begin
				reload_ff <= clampReload(hwdata[CNT_W-1:0]);
			end
			if (wrWarn) begin
				warn_ff <= hwdata[CNT_W-1:0];
			end
			if (wrWindow) begin
				window_ff <= hwdata[CNT_W-1:0];
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			count_ff <= RELOAD_RST;
		end else if (wdReset) begin
			count_ff <= RELOAD_RST;
		end else if (enableRise || feedGood || timeoutHit) begin
			count_ff <= reload_ff;
		end else if (stepNow) begin
			count_ff <= nxt_count;
		end
	end

	// prescaler phase, four ticks per count
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			psc_ff <= PSC_RST;
		end else if (wdReset || enableRise || feedGood || timeoutHit) begin
			psc_ff <= PSC_RST;
		end else if (running && guardTick) begin
			psc_ff <= psc_ff + 2'h1;
		end
	end

	// sticky status, set wins over clear
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			status_ff <= ST_RST;
		end else if (wdReset) begin
			status_ff <= ST_RST;
		end else if (wrStatus) begin
			status_ff <= (status_ff & ~hwdata[ST_W-1:0]) | evtSet;
		end else begin
			status_ff <= status_ff | evtSet;
		end
	end

	// interrupt mask
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mask_ff <= ST_RST;
		end else if (wdReset) begin
			mask_ff <= ST_RST;
		end else if (wrMask) begin
			mask_ff <= hwdata[ST_W-1:0];
		end
	end

	// watchdog reset cause flag, set wins
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cause_ff <= 1'b0;
		end else if (wdReset) begin
			cause_ff <= 1'b1;
		end else if (wrCause && hwdata[0]) begin
			cause_ff <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			chipReset_ff <= 1'b0;
		end else begin
			chipReset_ff <= wdReset;
		end
	end
	assign chipResetReq = chipReset_ff;

	assign irq = |(status_ff & mask_ff);
endmodule : windowed_timeout_guard
`default_nettype wire

// [tb/wtg_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module wtg_checker (
	input wire logic        mclk,
	input wire logic        resetn,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        chipResetReq,
	input wire logic        irq
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	// an accepted word transfer
	logic take;
	assign take = hsel && hready && htrans[1] && hsize == 3'h2;
	// one wait cycle, then the answer
	sequence rdWait;
		!hreadyout ##1 hreadyout;
	endsequence
	// no second trip right after one
	sequence quiet;
		!chipResetReq [*8];
	endsequence
	a_resp_okay: assert property (hresp == 1'h0)
		else $error("error response seen");
	a_read_wait: assert property (take && !hwrite |=> rdWait)
		else $error("read wait state wrong");
	a_write_nowait: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	a_wait_cause: assert property ($fell(hreadyout) |-> $past(take && !hwrite))
		else $error("stall without read");
	a_wait_single: assert property (!hreadyout |=> hreadyout)
		else $error("stall too long");
	a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
		else $error("read data moved");
	a_trip_pulse: assert property (chipResetReq |=> quiet)
		else $error("reset request not single");
	a_trip_clears: assert property (chipResetReq |-> ##2 !irq)
		else $error("interrupt kept over reset");
endmodule : wtg_checker
bind windowed_timeout_guard wtg_checker u_chk (
	.mclk, .resetn, .hsel, .htrans, .hwrite, .hsize, .hready,
	.hreadyout, .hresp, .hrdata, .chipResetReq, .irq
);
`default_nettype wire

// [tb/test_windowed_timeout_guard.sv]
`timescale 1ns/1ns
`default_nettype none
module test_windowed_timeout_guard;
	import wtg_pkg::*;
	localparam int TDIV = 2;
	localparam int STEP = 4 * TDIV;
	logic        mclk, resetn, hsel, hwrite, hready, hreadyout, hresp;
	logic        sleepMode, chipResetReq, irq, rdyN, irqN, rdPh;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [31:0] seed = 32'h95F25D8F;
	logic [31:0] expQ[$];
	int          mismatches = 0, checkCount = 0, trips = 0, cyc = 0, t0, t1, n;
	logic [7:0]  ofs [10] = '{OFS_MODE, OFS_RELOAD, OFS_FEED, OFS_COUNT, OFS_WARN,
		OFS_WINDOW, OFS_STATUS, OFS_MASK, OFS_CAUSE, 8'h40};
	logic [31:0] rst [10] = '{32'h0, 32'hFF, 32'h0, 32'hFF, 32'h0, 32'hFFFFFF,
		32'h0, 32'h0, 32'h0, 32'h0};
	assign hready = hreadyout;
	windowed_timeout_guard #(.TICK_DIV(TDIV)) u_dut (
		.mclk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hreadyout, .hresp, .hrdata, .sleepMode, .chipResetReq, .irq
	);
	// free running clock
	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) cyc <= cyc + 1;
	// comparison and reporting
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic completeRun;
		$display("checks %0d mismatches %0d", checkCount, mismatches);
		if (mismatches == 0 && checkCount > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : completeRun
	// xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// window check around an expected cycle count
	function automatic logic [31:0] near(input int x, input int e);
		return {31'h0, x >= e - STEP && x <= e + STEP};
	endfunction : near
	// one single transfer, held until ready is sampled high
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge mclk); while (!rdyN);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (!rdyN);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expQ.push_back(e);
		bus(1'h0, a, 32'h0);
	endtask : rd
	// key pair written back to back
	task automatic feed;
		wr(OFS_FEED, {24'h0, FEED_FIRST});
		wr(OFS_FEED, {24'h0, FEED_SECOND});
	endtask : feed
	// wait for the interrupt or a trip, bounded
	task automatic waitEv(input int lim);
		int k;
		k = trips;
		n = 0;
		while (!irqN && trips == k && n < lim) begin
			@(posedge mclk);
			n++;
		end
	endtask : waitEv
	task automatic irqIs(input logic e);
		@(negedge mclk);
		check({31'h0, irq}, {31'h0, e});
		@(posedge mclk);
	endtask : irqIs
	// output watcher: settled values seen mid cycle
	always @(negedge mclk) begin
		rdyN = hready;
		irqN = irq;
		if (chipResetReq)
			trips++;
		if (rdPh && hreadyout) begin
			check(hrdata, expQ.pop_front());
			rdPh = 1'h0;
		end
		if (hsel && htrans[1] && !hwrite && hreadyout)
			rdPh = 1'h1;
	end
	// hang guard
	initial begin
		#600000;
		mismatches++;
		completeRun();
	end
	initial begin
		{hsel, haddr, htrans, hwrite, hwdata, sleepMode, resetn, rdPh} = '0;
		hsize = HSIZE_WORD;
		repeat (12) @(posedge mclk);
		resetn <= 1'h1;
		@(posedge mclk);
		foreach (ofs[i]) rd(ofs[i], rst[i]);
		wr(8'h40, 32'hFFFFFFFF);
		rd(8'h40, 32'h0);
		hsize <= 3'h0;
		wr(OFS_MODE, 32'h1);
		hsize <= HSIZE_WORD;
		rd(OFS_MODE, 32'h0);
		wr(OFS_RELOAD, 32'h10);
		rd(OFS_RELOAD, 32'hFF);
		r = rnd();
		wr(OFS_WARN, r);
		rd(OFS_WARN, {8'h0, r[23:0]});
		r = rnd();
		wr(OFS_RELOAD, r);
		rd(OFS_RELOAD, r[23:0] < 24'hFF ? 32'hFF : {8'h0, r[23:0]});
		wr(OFS_RELOAD, 32'hFF);
		$display("done: registers");
		wr(OFS_MODE, 32'h5);
		wr(OFS_MODE, 32'h4);
		rd(OFS_MODE, 32'h5);
		wr(OFS_WARN, 32'h80);
		wr(OFS_MASK, 32'h3);
		feed();
		t0 = cyc;
		wr(OFS_RELOAD, 32'h1FF);
		rd(OFS_RELOAD, 32'hFF);
		waitEv(3000);
		check(near(cyc - t0, 127 * STEP), 32'h1);
		rd(OFS_STATUS, 32'h2);
		wr(OFS_STATUS, 32'h2);
		wr(OFS_RELOAD, 32'h1FF);
		rd(OFS_RELOAD, 32'h1FF);
		waitEv(3000);
		check(near(cyc - t0, 256 * STEP), 32'h1);
		wr(OFS_MASK, 32'h0);
		irqIs(1'h0);
		rd(OFS_STATUS, 32'h1);
		wr(OFS_STATUS, 32'h1);
		rd(OFS_STATUS, 32'h0);
		$display("done: interrupt mode");
		wr(OFS_WINDOW, 32'h10);
		wr(OFS_MASK, 32'h4);
		feed();
		irqIs(1'h1);
		rd(OFS_STATUS, 32'h4);
		wr(OFS_STATUS, 32'h7);
		wr(OFS_FEED, 32'h12);
		rd(OFS_STATUS, 32'h4);
		wr(OFS_STATUS, 32'h7);
		$display("done: early feed");
		wr(OFS_MODE, 32'h3);
		t0 = trips;
		wr(OFS_FEED, {24'h0, FEED_FIRST});
		wr(OFS_MODE, 32'h3);
		repeat (4) @(posedge mclk);
		check(trips - t0, 32'h1);
		rd(OFS_CAUSE, 32'h1);
		rd(OFS_MODE, 32'h0);
		rd(OFS_MASK, 32'h0);
		wr(OFS_CAUSE, 32'h1);
		rd(OFS_CAUSE, 32'h0);
		$display("done: bad feed");
		sleepMode <= 1'h1;
		wr(OFS_MODE, 32'h3);
		t0 = trips;
		repeat (3000) @(posedge mclk);
		check(trips - t0, 32'h0);
		wr(OFS_MODE, 32'hB);
		t1 = cyc;
		waitEv(3000);
		check(near(cyc - t1, 256 * STEP), 32'h1);
		check(trips - t0, 32'h1);
		rd(OFS_CAUSE, 32'h1);
		sleepMode <= 1'h0;
		$display("done: deep sleep");
		repeat (4) @(posedge mclk);
		check(expQ.size(), 32'h0);
		completeRun();
	end
endmodule : test_windowed_timeout_guard
`default_nettype wire
